// [src/cbo_pkg.sv]
package cbo_pkg;
    // ==========================================
    // register map: offsets are register indices, each register owns one word at four times it
    localparam int CBO_ADDR_W = 18;
    localparam logic [15:0] CBO_SEL_INDEX = 16'hFFA5;
    // redirection index is local to this block
    localparam logic [15:0] CBO_REDIR_INDEX = 16'hFFA8;
    localparam logic [17:0] CBO_SEL_ADDR = {CBO_SEL_INDEX, 2'h0};
    localparam logic [17:0] CBO_REDIR_ADDR = {CBO_REDIR_INDEX, 2'h0};
    localparam logic [17:0] CBO_ADDR_MASK = 18'h3FFFC;
    localparam logic [7:0] CBO_SEL_RESET = 8'h00;
    localparam logic [7:0] CBO_SEL_MASK = 8'h87;
    localparam logic [7:0] CBO_REDIR_RESET = 8'h00;
    localparam int CBO_SEL_LANE = 0;
    localparam int CBO_REDIR_LANE = 0;
    // ==========================================
    // field positions
    localparam int CBO_EN_BIT = 7;
    localparam int CBO_DIV_LSB = 0;
    localparam int CBO_DIV_W = 3;
    localparam int CBO_REDIR_BIT = 0;
    localparam int CBO_CNT_W = 12;
    // ==========================================
    // bus responses
    localparam logic [1:0] CBO_RESP_OKAY = 2'h0;
    localparam logic [1:0] CBO_RESP_SLVERR = 2'h2;
endpackage : cbo_pkg

// [src/cbo_clock_buzzer_output.sv]
`timescale 1ns/1ps
// Functional notes
// - Any reset clears the select register to zero: output off, undivided clock.
// - The select register takes full-byte writes via its byte strobe; single-bit changes are done as read-modify-write.
// - Select bit 7 enables the pin output; zero keeps the pin off.
// - Select bits 2:0 pick divide by 1 (realised as 2), 2, 4, 8, 16, 2^11, 2^12 or 2^13.
// - One pin carries the peripheral clock or buzzer tone at the chosen rate.
// - With the redirection bit set the output goes to the alternate pin.
// - Output starts or stops at the next half-period tick after the enable edge, with no runt pulse.
module cbo_clock_buzzer_output
    import cbo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [CBO_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CBO_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic clockBuzzerPin,
    output logic alternateOutputPin
);
    // ==========================================
    // AXI4-Lite write channel
    logic [7:0] clockOutputSelect;
    logic [7:0] pinRedirectionReg;
    logic [CBO_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic haveAw;
    logic haveW;
    logic doWrite;
    logic selHit;
    logic redirHit;

    assign doWrite = haveAw && haveW && !s_axi_bvalid;
    assign selHit = (wrAddr & CBO_ADDR_MASK) == (CBO_SEL_ADDR & CBO_ADDR_MASK);
    assign redirHit = (wrAddr & CBO_ADDR_MASK) == (CBO_REDIR_ADDR & CBO_ADDR_MASK);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            haveAw <= 1'b0;
            wrAddr <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            haveAw <= 1'b1;
            wrAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (doWrite) begin
            haveAw <= 1'b0;
        end else begin
            s_axi_awready <= !haveAw;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            haveW <= 1'b0;
            wrData <= 32'h00000000;
            wrStrb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            haveW <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (doWrite) begin
            haveW <= 1'b0;
        end else begin
            s_axi_wready <= !haveW;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CBO_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (selHit || redirHit) ? CBO_RESP_OKAY : CBO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clockOutputSelect <= CBO_SEL_RESET;
        end else if (doWrite && selHit && wrStrb[CBO_SEL_LANE]) begin
            // byte strobe lets a single-bit update be done as read-modify-write
            clockOutputSelect <= wrData[CBO_SEL_LANE*8 +: 8] & CBO_SEL_MASK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinRedirectionReg <= CBO_REDIR_RESET;
        end else if (doWrite && redirHit && wrStrb[CBO_REDIR_LANE]) begin
            pinRedirectionReg <= wrData[CBO_REDIR_LANE*8 +: 8] & 8'h01;
        end
    end

    // ==========================================
    // AXI4-Lite read channel
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp = CBO_RESP_OKAY;
        // each register sits alone in its own word
        if ((s_axi_araddr & CBO_ADDR_MASK) == (CBO_SEL_ADDR & CBO_ADDR_MASK)) begin
            next_rdata[CBO_SEL_LANE*8 +: 8] = clockOutputSelect;
        end else if ((s_axi_araddr & CBO_ADDR_MASK) == (CBO_REDIR_ADDR & CBO_ADDR_MASK)) begin
            next_rdata[CBO_REDIR_LANE*8 +: 8] = pinRedirectionReg;
        end else begin
            next_rresp = CBO_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= CBO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================
    // divider
    // free running prescaler; tick marks one half period of the chosen rate
    logic [CBO_CNT_W-1:0] prescale;
    logic tick;
    logic [CBO_DIV_W-1:0] divSel;
    logic enableBit;

    assign divSel = clockOutputSelect[CBO_DIV_LSB +: CBO_DIV_W];
    assign enableBit = clockOutputSelect[CBO_EN_BIT];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // half period in clk cycles: 2^(k-1) for codes 1-4, 2^(k+5) for codes 5-7; divide by 1 ticks every cycle on both phases
    always_comb begin
        unique case (divSel)
            3'h0: tick = 1'b1;
            3'h1: tick = 1'b1;
            3'h2: tick = prescale[0];
            3'h3: tick = &prescale[1:0];
            3'h4: tick = &prescale[2:0];
            3'h5: tick = &prescale[9:0];
            3'h6: tick = &prescale[10:0];
            3'h7: tick = &prescale[11:0];
        endcase
    end

    // ==========================================
    // gated square wave
    // enable is sampled only while the wave is low so no runt pulse appears
    logic wave;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wave <= 1'b0;
        end else if (tick) begin
            if (!wave) begin
                wave <= enableBit;
            end else begin
                wave <= 1'b0;
            end
        end
    end

    // divide by 1: the pin follows clk level is impossible from a flop, so it toggles each cycle
    // giving clk/2; the undivided code is realised at the highest rate one flop can produce
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clockBuzzerPin <= 1'b0;
            alternateOutputPin <= 1'b0;
        end else begin
            clockBuzzerPin <= wave && !pinRedirectionReg[CBO_REDIR_BIT];
            alternateOutputPin <= wave && pinRedirectionReg[CBO_REDIR_BIT];
        end
    end
endmodule : cbo_clock_buzzer_output

// [bench/cbo_props.sv]
`timescale 1ns/1ps
// ====
// bus and pin checks
module cbo_props
    import cbo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clockBuzzerPin,
    input wire logic alternateOutputPin
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_PIN_EXCL: assert property (!(clockBuzzerPin && alternateOutputPin))
        else $error("both pins driven");
    AST_UNUSED_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[6:3] == 4'h0)
        else $error("unused bits not zero");
    AST_SLVERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == CBO_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read data not zero");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    AST_W_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write response");
    AST_R_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(clockBuzzerPin));
    cover property ($rose(alternateOutputPin));
endmodule : cbo_props

bind cbo_clock_buzzer_output cbo_props u_props (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .clockBuzzerPin(clockBuzzerPin), .alternateOutputPin(alternateOutputPin));

// [bench/cbo_buzzer_model.sv]
`timescale 1ns/1ps
// ====
// listener on the pin: run length of each level
module cbo_buzzer_model (
    input wire logic clk,
    input wire logic pin,
    output int highLen,
    output int lowLen,
    output int edges
);
    logic last = 1'b0;
    int run = 0;
    // pin is taken as a plain push-pull output with the port side cleared
    always @(posedge clk) begin
        if (pin !== last) begin
            if (last) begin
                highLen <= run;
            end else begin
                lowLen <= run;
            end
            run <= 1;
            edges <= edges + 1;
        end else begin
            run <= run + 1;
        end
        last <= pin;
    end
endmodule : cbo_buzzer_model

// [bench/cbo_clock_buzzer_output_tb.sv]
`timescale 1ns/1ps
// ====
// bench top
module cbo_clock_buzzer_output_tb
    import cbo_pkg::*;
;
    localparam logic [CBO_ADDR_W-1:0] BASE = CBO_SEL_ADDR;
    localparam logic [CBO_ADDR_W-1:0] REDIR = CBO_REDIR_ADDR;
    logic clk = 0, sysRst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [CBO_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, pin, alt;
    logic [1:0] bresp, rresp, r;
    int failures = 0, num_checks = 0, hl, ll, ed, ed2, e, h;
    always #20 clk = ~clk;
    cbo_clock_buzzer_output DUT (.clk(clk), .sys_rst(sysRst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clockBuzzerPin(pin), .alternateOutputPin(alt));
    cbo_buzzer_model M1 (.clk(clk), .pin(pin), .highLen(hl), .lowLen(ll), .edges(ed));
    cbo_buzzer_model M2 (.clk(clk), .pin(alt), .highLen(), .lowLen(), .edges(ed2));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic wr(input logic [CBO_ADDR_W-1:0] a, input logic [31:0] v, input logic [3:0] s);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [CBO_ADDR_W-1:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic sel(input logic [7:0] v);
        wr(BASE, 32'(v) << (8 * CBO_SEL_LANE), 4'(1 << CBO_SEL_LANE));
    endtask : sel
    task automatic t_div;
        for (int c = 0; c < 8; c++) begin
            h = (c <= 1) ? 1 : (c <= 4) ? (1 << (c - 1)) : (1 << (c + 5));
            sel(8'(c));
            sel(8'h80 | 8'(c));
            e = ed + 3;
            while (ed < e) @(posedge clk);
            chk("high", 32'(hl), 32'(h));
            chk("low", 32'(ll), 32'(h));
            sel(8'(c));
            repeat (2 * h + 4) @(posedge clk);
            e = ed;
            repeat (2 * h + 4) @(posedge clk);
            chk("stopped", 32'(ed - e), 0);
            chk("idle", 32'(pin), 0);
        end
    endtask : t_div
    task automatic t_redir;
        sel(8'h02);
        wr(REDIR, 32'hFFFF_FF01, 4'(1 << CBO_REDIR_LANE));
        rd(BASE);
        chk("select", d, 32'h0000_0002);
        rd(REDIR);
        chk("redir", d, 32'h0000_0001);
        e = ed2 + 4;
        h = ed;
        sel(8'h82);
        repeat (40) @(posedge clk);
        chk("main", 32'(ed - h), 0);
        chk("alt", 32'(ed2 > e), 1);
    endtask : t_redir
    task automatic t_reset;
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        chk("rst pins", 32'(pin | alt), 0);
        rd(BASE);
        chk("rst select", d, 32'(CBO_SEL_RESET));
        rd(REDIR);
        chk("rst redir", d, 32'(CBO_REDIR_RESET));
    endtask : t_reset
    task automatic t_unmapped;
        wr('0, 32'hFFFF_FFFF, 4'hF);
        chk("wresp", 32'(r), 32'(CBO_RESP_SLVERR));
        rd('0);
        chk("rresp", 32'(r), 32'(CBO_RESP_SLVERR));
        chk("rdata", d, 32'h0);
    endtask : t_unmapped
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        rd(BASE);
        chk("reset", d, 32'(CBO_SEL_RESET));
        sel(8'h7F);
        rd(BASE);
        chk("unused", d, 32'(8'h7F & CBO_SEL_MASK) << (8 * CBO_SEL_LANE));
        t_div;
        t_redir;
        t_reset;
        t_unmapped;
        final_report;
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        final_report;
    end
endmodule : cbo_clock_buzzer_output_tb
